// ---- i2c_status_params.svh ----
// How it works
// - Status byte readable whole or by bit
// - Reset clears every status flag to zero
// - Bit order master down to stop flag
// - Master flag shows master communication state
// - Generated start condition sets master flag
// - Stop, loss, exit, disable clear master
// - Loss flag low unless arbitration lost
// - Arbitration loss sets flag, clears master
// - Status read or disable clears loss flag
// - Foreign bit operation also clears loss flag
// - Eighth clock sets extension flag on 0000/1111
// - Start, stop, exit, disable clear extension
// - Exit is control bit 6, enable bit 7
// - Match flag shows own address match
`ifndef I2C_STATUS_PARAMS_SVH
`define I2C_STATUS_PARAMS_SVH

`define STATUS_ADDR 16'hFFA9
`define STATUS_RST 8'h00
`define BIT_MASTER 7
`define BIT_ARB_LOST 6
`define BIT_EXT_CODE 5
`define BIT_ADDR_MATCH 4
`define BIT_TX_MODE 3
`define BIT_ACK_SEEN 2
`define BIT_START_SEEN 1
`define BIT_STOP_SEEN 0
`define CTRL_EXIT_BIT 6
`define CTRL_ENABLE_BIT 7
`define EXT_CODE_LO 4'h0
`define EXT_CODE_HI 4'hF
`define ADDR_LAST_CNT 4'h7
`define ACK_CNT 4'h8

`endif

// ---- i2c_status_pkg.sv ----
package i2c_status_pkg;
    typedef logic [7:0] byte_t;
    typedef logic [15:0] addr_t;
    typedef enum logic [2:0] {
        PH_IDLE = 3'b001,
        PH_ADDR = 3'b010,
        PH_DATA = 3'b100
    } phase_t;
endpackage

// ---- i2c_status_flags.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "i2c_status_params.svh"

module i2c_status_flags (
    input wire logic clk,
    input wire logic rst,
    input wire i2c_status_pkg::addr_t cpu_addr,
    input wire logic cpu_rd,
    input wire logic cpu_wr,
    input wire logic cpu_bitop,
    output i2c_status_pkg::byte_t cpu_rdata,
    input wire i2c_status_pkg::byte_t ctrl_reg,
    input wire logic ctrl_wr,
    input wire i2c_status_pkg::byte_t ctrl_wdata,
    input wire logic [6:0] own_addr,
    input wire logic start_gen,
    input wire logic arb_lost_evt,
    input wire logic tx_mode,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic master_active_flag,
    output logic arb_lost_flag
);
    import i2c_status_pkg::*;

    ////////////////////////////////////////////////////////////////
    // Pin synchronisers and edge detection
    logic scl_meta_r, scl_sync_r, scl_prev_r;
    logic sda_meta_r, sda_sync_r, sda_prev_r;
    logic scl_rise, start_det, stop_det;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            scl_meta_r <= 1'b1;
            scl_sync_r <= 1'b1;
            scl_prev_r <= 1'b1;
            sda_meta_r <= 1'b1;
            sda_sync_r <= 1'b1;
            sda_prev_r <= 1'b1;
        end else begin
            scl_meta_r <= scl_in;
            scl_sync_r <= scl_meta_r;
            scl_prev_r <= scl_sync_r;
            sda_meta_r <= sda_in;
            sda_sync_r <= sda_meta_r;
            sda_prev_r <= sda_sync_r;
        end
    end

    assign scl_rise = scl_sync_r && !scl_prev_r;
    assign start_det = scl_sync_r && scl_prev_r && sda_prev_r && !sda_sync_r;
    assign stop_det = scl_sync_r && scl_prev_r && !sda_prev_r && sda_sync_r;

    ////////////////////////////////////////////////////////////////
    // Control register decode
    logic enable_prev_r;
    logic exit_wr, en_fall;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            enable_prev_r <= 1'b0;
        end else begin
            enable_prev_r <= ctrl_reg[`CTRL_ENABLE_BIT];
        end
    end

    assign exit_wr = ctrl_wr && ctrl_wdata[`CTRL_EXIT_BIT];
    assign en_fall = enable_prev_r && !ctrl_reg[`CTRL_ENABLE_BIT];

    ////////////////////////////////////////////////////////////////
    // Byte framing on the serial bus
    phase_t phase_r;
    logic [3:0] bit_cnt_r;
    logic [7:0] shift_r;
    logic eighth_rise, ninth_rise, ext_hit, match_hit;

    assign eighth_rise = scl_rise && (phase_r == PH_ADDR) && (bit_cnt_r == `ADDR_LAST_CNT);
    assign ninth_rise = scl_rise && (phase_r != PH_IDLE) && (bit_cnt_r == `ACK_CNT);
    assign ext_hit = (shift_r[6:3] == `EXT_CODE_LO) || (shift_r[6:3] == `EXT_CODE_HI);
    assign match_hit = (shift_r[6:0] == own_addr);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            phase_r <= PH_IDLE;
        end else begin
            case (phase_r)
                PH_IDLE: if (start_det) phase_r <= PH_ADDR;
                PH_ADDR: begin
                    if (stop_det) phase_r <= PH_IDLE;
                    else if (ninth_rise) phase_r <= PH_DATA;
                end
                PH_DATA: begin
                    if (stop_det) phase_r <= PH_IDLE;
                    else if (start_det) phase_r <= PH_ADDR;
                end
                default: phase_r <= PH_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            bit_cnt_r <= 4'h0;
            shift_r <= 8'h00;
        end else if (start_det || stop_det) begin
            bit_cnt_r <= 4'h0;
            shift_r <= 8'h00;
        end else if (scl_rise && phase_r != PH_IDLE) begin
            bit_cnt_r <= ninth_rise ? 4'h0 : bit_cnt_r + 4'h1;
            if (bit_cnt_r < `ACK_CNT) shift_r <= {shift_r[6:0], sda_sync_r};
        end
    end

    ////////////////////////////////////////////////////////////////
    // Status flags
    logic ext_code_flag, addr_match_flag, ack_seen_flag;
    logic start_seen_flag, stop_seen_flag, tx_mode_flag;
    logic rd_hit, foreign_bitop;
    byte_t status;

    assign rd_hit = cpu_rd && (cpu_addr == `STATUS_ADDR);
    assign foreign_bitop = cpu_bitop && (cpu_addr != `STATUS_ADDR);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            master_active_flag <= 1'b0;
        end else if (arb_lost_evt) begin
            master_active_flag <= 1'b0;
        end else if (start_gen) begin
            master_active_flag <= 1'b1;
        end else if (stop_det || exit_wr || en_fall) begin
            master_active_flag <= 1'b0;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            arb_lost_flag <= 1'b0;
        end else if (arb_lost_evt) begin
            arb_lost_flag <= 1'b1;
        end else if (rd_hit || foreign_bitop || en_fall) begin
            arb_lost_flag <= 1'b0;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ext_code_flag <= 1'b0;
        end else if (eighth_rise && ext_hit) begin
            ext_code_flag <= 1'b1;
        end else if (start_det || stop_det || exit_wr || en_fall) begin
            ext_code_flag <= 1'b0;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            addr_match_flag <= 1'b0;
        end else if (eighth_rise) begin
            addr_match_flag <= match_hit;
        end else if (start_det || stop_det || exit_wr || en_fall) begin
            addr_match_flag <= 1'b0;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ack_seen_flag <= 1'b0;
            start_seen_flag <= 1'b0;
            stop_seen_flag <= 1'b0;
            tx_mode_flag <= 1'b0;
        end else begin
            tx_mode_flag <= tx_mode && ctrl_reg[`CTRL_ENABLE_BIT];
            if (ninth_rise) ack_seen_flag <= !sda_sync_r;
            else if (scl_rise || start_det || stop_det || en_fall) ack_seen_flag <= 1'b0;
            if (start_det) start_seen_flag <= 1'b1;
            else if (stop_det || exit_wr || en_fall) start_seen_flag <= 1'b0;
            if (stop_det) stop_seen_flag <= 1'b1;
            else if (start_det || en_fall) stop_seen_flag <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////
    // CPU read port
    // bit layout
    always_comb begin
        status = `STATUS_RST;
        status[`BIT_MASTER] = master_active_flag;
        status[`BIT_ARB_LOST] = arb_lost_flag;
        status[`BIT_EXT_CODE] = ext_code_flag;
        status[`BIT_ADDR_MATCH] = addr_match_flag;
        status[`BIT_TX_MODE] = tx_mode_flag;
        status[`BIT_ACK_SEEN] = ack_seen_flag;
        status[`BIT_START_SEEN] = start_seen_flag;
        status[`BIT_STOP_SEEN] = stop_seen_flag;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cpu_rdata <= `STATUS_RST;
        end else if (rd_hit) begin
            cpu_rdata <= status;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_eighth_ext;
        eighth_rise && ext_hit;
    endsequence

    sequence s_ext_clear;
        (start_det || stop_det || exit_wr || en_fall) && !(eighth_rise && ext_hit);
    endsequence

    a_reset_clears_all: assert property ($fell(rst) |-> status == 8'h00)
        else $error("status not zero after reset");
    a_start_sets_master: assert property (start_gen && !arb_lost_evt
        |=> master_active_flag)
        else $error("start did not set master flag");
    a_master_clears: assert property ((arb_lost_evt || ((stop_det || exit_wr || en_fall) && !start_gen))
        |=> !master_active_flag)
        else $error("master flag not cleared");
    a_loss_sets_both: assert property (arb_lost_evt |=> arb_lost_flag && !master_active_flag)
        else $error("arbitration loss not reported");
    a_loss_only_event: assert property ($rose(arb_lost_flag) |-> $past(arb_lost_evt))
        else $error("loss flag rose without loss");
    a_read_clears_loss: assert property ((rd_hit || foreign_bitop || en_fall) && !arb_lost_evt
        |=> !arb_lost_flag)
        else $error("loss flag not cleared");
    a_bitop_clears_loss: assert property (foreign_bitop && arb_lost_flag && !arb_lost_evt
        |=> $fell(arb_lost_flag))
        else $error("foreign bit operation kept loss flag");
    a_ext_on_eighth: assert property (s_eighth_ext |=> ext_code_flag)
        else $error("extension code missed");
    a_ext_clears: assert property (s_ext_clear |=> !ext_code_flag)
        else $error("extension flag not cleared");
    a_match_on_eighth: assert property (eighth_rise |=> addr_match_flag == $past(match_hit))
        else $error("address match wrong");
    a_read_data: assert property (rd_hit |=> cpu_rdata == $past(status))
        else $error("read data wrong");
    a_write_ignored: assert property (cpu_wr && !rd_hit |=> $stable(cpu_rdata))
        else $error("write changed read data");
    a_bit_layout: assert property (rd_hit |=> (cpu_rdata[7] == $past(master_active_flag))
        && (cpu_rdata[6] == $past(arb_lost_flag)) && (cpu_rdata[5] == $past(ext_code_flag))
        && (cpu_rdata[4] == $past(addr_match_flag)) && (cpu_rdata[0] == $past(stop_seen_flag)))
        else $error("status bit order wrong");
endmodule

`default_nettype wire

// ---- i2c_bus_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module i2c_bus_model (
    output logic scl,
    output logic sda
);
    import i2c_status_pkg::*;
    initial begin
        scl = 1'b1;
        sda = 1'b1;
    end
    ////////////////////////////////////////////////////////////
    task automatic start();
        sda = 1'b0;
        #62.5;
        scl = 1'b0;
        #31;
    endtask
    task automatic send_byte(input byte_t b, input logic ack);
        for (int i = 8; i >= 0; i--) begin
            // Ninth bit: low for acknowledge, else released high
            sda = (i == 0) ? !ack : b[i-1];
            #31;
            scl = 1'b1;
            #62.5;
            scl = 1'b0;
            #31.5;
        end
    endtask
    task automatic stop();
        sda = 1'b0;
        #31;
        scl = 1'b1;
        #62.5;
        sda = 1'b1;
        #62.5;
    endtask
endmodule
`default_nettype wire

// ---- test_i2c_status_flags.sv ----
`timescale 1ns/1ps
`default_nettype none
module test_i2c_status_flags;
    import i2c_status_pkg::*;
    logic clk, rst, cpu_rd, cpu_wr, cpu_bitop, ctrl_wr, start_gen, arb_lost_evt, tx_mode;
    addr_t cpu_addr;
    byte_t cpu_rdata, ctrl_reg, ctrl_wdata, ab;
    logic [6:0] own_addr;
    wire logic scl, sda;
    wire logic master_active_flag, arb_lost_flag;
    int errors = 0, cmp_count = 0, seed = 6587;
    int m_ms = 0, m_al = 0, m_ex = 0, m_am = 0;
    int m_tx = 0, m_ack = 0, m_st = 0, m_sp = 0;
    i2c_status_flags u_i2c_status_flags (.clk(clk), .rst(rst), .cpu_addr(cpu_addr), .cpu_rd(cpu_rd),
        .cpu_wr(cpu_wr), .cpu_bitop(cpu_bitop), .cpu_rdata(cpu_rdata), .ctrl_reg(ctrl_reg),
        .ctrl_wr(ctrl_wr), .ctrl_wdata(ctrl_wdata), .own_addr(own_addr), .start_gen(start_gen),
        .arb_lost_evt(arb_lost_evt), .tx_mode(tx_mode), .scl_in(scl), .sda_in(sda),
        .master_active_flag(master_active_flag), .arb_lost_flag(arb_lost_flag));
    i2c_bus_model u_i2c_bus_model (.scl(scl), .sda(sda));
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////
    task automatic check(input byte_t seen, input byte_t exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic rd();
        byte_t exp;
        exp = {m_ms[0], m_al[0], m_ex[0], m_am[0], m_tx[0], m_ack[0], m_st[0], m_sp[0]};
        cpu_addr <= 16'hFFA9;
        cpu_rd <= 1'b1;
        cyc(1);
        cpu_rd <= 1'b0;
        @(negedge clk);
        check(cpu_rdata, exp);
        cyc(1);
        m_al = 0;
    endtask
    task automatic pulse(input int k);
        case (k)
            0: begin
                start_gen <= 1'b1;
                m_ms = 1;
            end
            1: begin
                arb_lost_evt <= 1'b1;
                m_al = 1;
                m_ms = 0;
            end
            2: begin
                ctrl_wr <= 1'b1;
                ctrl_wdata <= 8'h40;
                m_ms = 0;
                m_ex = 0;
                m_am = 0;
                m_st = 0;
            end
            3: begin
                cpu_bitop <= 1'b1;
                cpu_addr <= 16'h0020;
                m_al = 0;
            end
            default: begin
                cpu_wr <= 1'b1;
                cpu_addr <= 16'hFFA9;
            end
        endcase
        cyc(1);
        {start_gen, arb_lost_evt, ctrl_wr, cpu_bitop, cpu_wr} <= 5'h00;
        @(negedge clk);
        check({6'h00, master_active_flag, arb_lost_flag}, {6'h00, m_ms[0], m_al[0]});
        cyc(1);
    endtask
    initial begin
        #200us;
        errors++;
        summarize();
    end
    initial begin
        {rst, cpu_rd, cpu_wr, cpu_bitop, ctrl_wr, start_gen, arb_lost_evt, tx_mode} = 8'h80;
        cpu_addr = 16'h0000;
        ctrl_reg = 8'h80;
        ctrl_wdata = 8'h00;
        own_addr = 7'h50;
        cyc(10);
        rst <= 1'b0;
        cyc(1);
        @(negedge clk);
        check(cpu_rdata, 8'h00);
        cyc(1);
        rd();
        $display("test reset done");
        pulse(0);
        rd();
        pulse(4);
        pulse(1);
        rd();
        rd();
        pulse(1);
        pulse(3);
        pulse(0);
        pulse(2);
        $display("test events done");
        pulse(0);
        pulse(1);
        pulse(0);
        ctrl_reg <= 8'h00;
        m_ms = 0;
        m_al = 0;
        cyc(3);
        ctrl_reg <= 8'h80;
        rd();
        $display("test disable done");
        for (int i = 0; i < 8; i++) begin
            ab = (i == 0) ? 8'hA0 : (i == 1) ? 8'h0E : (i == 2) ? 8'hF3 : byte_t'($random(seed));
            own_addr <= (i == 3) ? ab[7:1] : 7'h50;
            m_tx = $random(seed) & 1;
            tx_mode <= m_tx[0];
            pulse(0);
            u_i2c_bus_model.start();
            m_ack = i % 2;
            u_i2c_bus_model.send_byte(ab, m_ack[0]);
            m_st = 1;
            m_sp = 0;
            cyc(8);
            m_ex = (ab[7:4] == 4'h0 || ab[7:4] == 4'hF) ? 1 : 0;
            m_am = (ab[7:1] == own_addr) ? 1 : 0;
            rd();
            if (i == 4) begin
                pulse(2);
                rd();
            end
            u_i2c_bus_model.stop();
            cyc(8);
            m_ms = 0;
            m_ex = 0;
            m_am = 0;
            m_ack = 0;
            m_st = 0;
            m_sp = 1;
            rd();
        end
        $display("test bus done");
        summarize();
    end
endmodule
`default_nettype wire
